// *** pkg/pdc_pkg.sv ***
/*
  constants shared by the decade counter/latch and its pin synchroniser.
  assumes a single 100 MHz system clock; nothing here is synthesised on its own.
*/
package pdc_pkg;
  localparam int DATA_W = 4;
  // bit layout of the synchronised pin vector
  localparam int PIN_W = 8;
  localparam int PIN_DATA_LSB = 0;
  localparam int PIN_CLK1 = 4;
  localparam int PIN_CLK2 = 5;
  localparam int PIN_LOAD_N = 6;
  localparam int PIN_CLEAR_N = 7;
  // reset values
  localparam logic [PIN_W-1:0] PIN_RESET = 8'h00;
  localparam logic [DATA_W-1:0] Q_RESET = 4'h0;
  // divide-by-five stage: last state before wrap
  localparam logic [2:0] DIV5_LAST = 3'h4;
  localparam logic [2:0] DIV5_FIRST = 3'h0;
endpackage

// *** pkg/pdc_pin_if.sv ***
/*
  synchronised pin levels and clock-fall pulses passed from the synchroniser
  to the counter core. one clock domain, driven by pdc_sync only.
*/
`timescale 1ns/1ns
interface pdc_pin_if;
  logic clk1_fall;
  logic clk2_fall;
  logic load_n;
  logic clear_n;
  logic [pdc_pkg::DATA_W-1:0] data;

  modport src (
    output clk1_fall,
    output clk2_fall,
    output load_n,
    output clear_n,
    output data
  );
  modport dst (
    input clk1_fall,
    input clk2_fall,
    input load_n,
    input clear_n,
    input data
  );
endinterface

// *** hdl/pdc_sync.sv ***
/*
  two-flop synchroniser for every pin of the counter/latch, plus falling-edge
  detection on the two count clocks. assumes pin clocks well below half of clk.
*/
`timescale 1ns/1ns
module pdc_sync (
  // system
  input wire logic clk,
  input wire logic nrst,
  // raw pins
  input wire logic [pdc_pkg::PIN_W-1:0] pins_raw,
  // synchronised side
  pdc_pin_if.src pins
);
  logic [pdc_pkg::PIN_W-1:0] meta_reg;
  logic [pdc_pkg::PIN_W-1:0] sync_reg;
  logic [1:0] clk_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // meta stage read only by the sync stage
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_reg <= pdc_pkg::PIN_RESET;
      sync_reg <= pdc_pkg::PIN_RESET;
    end else begin
      meta_reg <= pins_raw;
      sync_reg <= meta_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      clk_prev_reg <= 2'h0;
    end else begin
      clk_prev_reg <= {sync_reg[pdc_pkg::PIN_CLK2], sync_reg[pdc_pkg::PIN_CLK1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign pins.clk1_fall = clk_prev_reg[0] & ~sync_reg[pdc_pkg::PIN_CLK1];
  assign pins.clk2_fall = clk_prev_reg[1] & ~sync_reg[pdc_pkg::PIN_CLK2];
  assign pins.load_n = sync_reg[pdc_pkg::PIN_LOAD_N];
  assign pins.clear_n = sync_reg[pdc_pkg::PIN_CLEAR_N];
  assign pins.data = sync_reg[pdc_pkg::PIN_DATA_LSB +: pdc_pkg::DATA_W];
endmodule

// *** hdl/pdc_counter.sv ***
/*
  presettable decade counter / four-bit latch: a divide-by-two stage on
  count clock 1 (q0) and a divide-by-five stage on count clock 2 (q3..q1).
  assumes all pins come from outside clk's domain; they pass pdc_sync first,
  so every pin effect appears three clk edges after the pin moves.
*/
`timescale 1ns/1ns
//Contract
//[RULE1] four flops: divide-by-two and divide-by-five stages
//[RULE2] load low: outputs follow data, clocks ignored
//[RULE3] load high, no clock: outputs hold
//[RULE4] stages advance only on falling clock edges
//[RULE5] clear low forces all outputs low
//[RULE6] clock1 feeds div-two, clock2 feeds div-five
module pdc_counter (
  // system
  input wire logic clk,
  input wire logic nrst,
  // count clocks
  input wire logic count_clk1,
  input wire logic count_clk2,
  // control
  input wire logic load_n,
  input wire logic clear_n,
  // parallel data
  input wire logic [pdc_pkg::DATA_W-1:0] data_in,
  // outputs
  output logic [pdc_pkg::DATA_W-1:0] q_out
);
  pdc_pin_if pins ();

  logic q0_reg;
  logic q0_next;
  logic [2:0] div5_reg;
  logic [2:0] div5_next;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  pdc_sync pdc_sync_inst (
    .clk(clk),
    .nrst(nrst),
    .pins_raw({clear_n, load_n, count_clk2, count_clk1, data_in}),
    .pins(pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state: clear over load over count
  always_comb begin
    q0_next = q0_reg;
    div5_next = div5_reg;
    if (!pins.clear_n) begin
      q0_next = pdc_pkg::Q_RESET[0]; // [RULE5]
      div5_next = pdc_pkg::Q_RESET[3:1]; // [RULE5]
    end else if (!pins.load_n) begin
      q0_next = pins.data[0]; // [RULE2]
      div5_next = pins.data[3:1]; // [RULE2]
    end else begin
      // [RULE3] no fall pulse leaves both stages alone
      if (pins.clk1_fall) begin
        q0_next = ~q0_reg; // [RULE1] [RULE4] [RULE6]
      end
      if (pins.clk2_fall) begin
        // preset states above four wrap to zero as well
        if (div5_reg >= pdc_pkg::DIV5_LAST) begin
          div5_next = pdc_pkg::DIV5_FIRST; // [RULE1] [RULE6]
        end else begin
          div5_next = div5_reg + 3'h1; // [RULE1] [RULE4]
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      q0_reg <= pdc_pkg::Q_RESET[0];
    end else begin
      q0_reg <= q0_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      div5_reg <= pdc_pkg::Q_RESET[3:1];
    end else begin
      div5_reg <= div5_next;
    end
  end

  assign q_out = {div5_reg, q0_reg};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_div2_toggle;
    @(posedge clk) disable iff (!nrst)
    (pins.clear_n && pins.load_n && pins.clk1_fall) |=> (q_out[0] != $past(q_out[0]));
  endproperty
  a_div2_toggle: assert property (p_div2_toggle) // [RULE1]
    else $error("divide-by-two stage did not toggle");

  property p_div5_wrap;
    @(posedge clk) disable iff (!nrst)
    (pins.clear_n && pins.load_n && pins.clk2_fall && q_out[3:1] == 3'h4)
      |=> (q_out[3:1] == 3'h0);
  endproperty
  a_div5_wrap: assert property (p_div5_wrap) // [RULE1]
    else $error("divide-by-five stage did not wrap after four");

  property p_div5_step;
    @(posedge clk) disable iff (!nrst)
    (pins.clear_n && pins.load_n && pins.clk2_fall && q_out[3:1] < 3'h4)
      |=> (q_out[3:1] == $past(q_out[3:1]) + 3'h1);
  endproperty
  a_div5_step: assert property (p_div5_step) // [RULE1]
    else $error("divide-by-five stage did not advance by one");

  property p_load_follow;
    @(posedge clk) disable iff (!nrst)
    (pins.clear_n && !pins.load_n) |=> (q_out == $past(pins.data));
  endproperty
  a_load_follow: assert property (p_load_follow) // [RULE2]
    else $error("outputs did not follow data while loading");

  property p_latch_hold;
    @(posedge clk) disable iff (!nrst)
    (!pins.load_n ##1 (pins.load_n && pins.clear_n && !pins.clk1_fall && !pins.clk2_fall)[*2])
      |=> (q_out == $past(q_out, 2));
  endproperty
  a_latch_hold: assert property (p_latch_hold) // [RULE3]
    else $error("latched value changed without clock activity");

  property p_no_edge_no_change;
    @(posedge clk) disable iff (!nrst)
    (pins.clear_n && pins.load_n && !pins.clk2_fall) |=> $stable(q_out[3:1]);
  endproperty
  a_no_edge_no_change: assert property (p_no_edge_no_change) // [RULE4]
    else $error("divide-by-five stage moved without a falling edge");

  property p_clear_low;
    @(posedge clk) disable iff (!nrst)
    !pins.clear_n |=> (q_out == 4'h0);
  endproperty
  a_clear_low: assert property (p_clear_low) // [RULE5]
    else $error("outputs not low while clear is asserted");

  property p_clk2_only_div5;
    @(posedge clk) disable iff (!nrst)
    (pins.clear_n && pins.load_n && !pins.clk1_fall) |=> $stable(q_out[0]);
  endproperty
  a_clk2_only_div5: assert property (p_clk2_only_div5) // [RULE6]
    else $error("divide-by-two stage moved without clock one");

  ////////////////////////////////////////////////////////////////////////////
  // priority, hold, preset wrap and fall-pulse shape
  property p_load_over_count;
    @(posedge clk) disable iff (!nrst)
    (pins.clear_n && !pins.load_n && (pins.clk1_fall || pins.clk2_fall))
      |=> (q_out == $past(pins.data));
  endproperty
  a_load_over_count: assert property (p_load_over_count) // [RULE2]
    else $error("count edge disturbed a load");

  property p_div5_high_wrap;
    @(posedge clk) disable iff (!nrst)
    (pins.clear_n && pins.load_n && pins.clk2_fall && q_out[3:1] > pdc_pkg::DIV5_LAST)
      |=> (q_out[3:1] == pdc_pkg::DIV5_FIRST);
  endproperty
  a_div5_high_wrap: assert property (p_div5_high_wrap) // [RULE1]
    else $error("preset divide-by-five state above four did not wrap");

  property p_div5_range;
    @(posedge clk) disable iff (!nrst)
    (pins.clear_n && pins.load_n && pins.clk2_fall)
      |=> (q_out[3:1] <= pdc_pkg::DIV5_LAST);
  endproperty
  a_div5_range: assert property (p_div5_range) // [RULE1]
    else $error("divide-by-five stage counted outside zero to four");

  property p_hold_no_fall;
    @(posedge clk) disable iff (!nrst)
    (pins.clear_n && pins.load_n && !pins.clk1_fall && !pins.clk2_fall)
      |=> $stable(q_out);
  endproperty
  a_hold_no_fall: assert property (p_hold_no_fall) // [RULE3]
    else $error("outputs moved with no count edge and no load");

  property p_latch_ignores_data;
    @(posedge clk) disable iff (!nrst)
    (pins.clear_n && pins.load_n && !pins.clk1_fall && !pins.clk2_fall
      && pins.data != q_out) |=> (q_out != $past(pins.data));
  endproperty
  a_latch_ignores_data: assert property (p_latch_ignores_data) // [RULE3]
    else $error("latched outputs took new data while load was high");

  property p_clear_wins;
    @(posedge clk) disable iff (!nrst)
    (!pins.clear_n && !pins.load_n)
      |=> (q_out == pdc_pkg::Q_RESET);
  endproperty
  a_clear_wins: assert property (p_clear_wins) // [RULE5]
    else $error("load won over clear");

  property p_clear_over_counts;
    @(posedge clk) disable iff (!nrst)
    (!pins.clear_n && (pins.clk1_fall || pins.clk2_fall))
      |=> (q_out == pdc_pkg::Q_RESET);
  endproperty
  a_clear_over_counts: assert property (p_clear_over_counts) // [RULE5]
    else $error("count edge moved outputs while clear was low");

  property p_reset_zero;
    @(posedge clk)
    !nrst |=> (q_out == pdc_pkg::Q_RESET);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("outputs not zero after reset");

  property p_clk1_fall_single;
    @(posedge clk) disable iff (!nrst)
    pins.clk1_fall |=> !pins.clk1_fall;
  endproperty
  a_clk1_fall_single: assert property (p_clk1_fall_single) // [RULE4]
    else $error("clock one fall pulse lasted more than one cycle");

  property p_clk2_fall_single;
    @(posedge clk) disable iff (!nrst)
    pins.clk2_fall |=> !pins.clk2_fall;
  endproperty
  a_clk2_fall_single: assert property (p_clk2_fall_single) // [RULE4]
    else $error("clock two fall pulse lasted more than one cycle");
endmodule

// *** testbench/pdc_board.sv ***
/*
  board wiring in front of the counter's second count clock.
  assumes the bench drives clock 2 directly unless ripple mode is chosen.
*/
`timescale 1ns/1ns
module pdc_board (
  // board controls
  input wire logic ripple,
  input wire logic clk2_src,
  // from the counter
  input wire logic q0,
  // to the counter
  output logic count_clk2
);
  // decade mode: div-two output clocks the div-five stage
  assign count_clk2 = ripple ? q0 : clk2_src;
endmodule

// *** testbench/tb_presettable_decade_counter_latch.sv ***
/*
  self-checking bench for the decade counter/latch.
  assumes a 3-edge pin latency; waits 8 edges after each pin move.
*/
`timescale 1ns/1ns
module tb_presettable_decade_counter_latch;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic count_clk1 = 1'b1;
  logic clk2_src = 1'b1;
  logic ripple = 1'b0;
  logic count_clk2;
  logic load_n = 1'b1;
  logic clear_n = 1'b1;
  logic [pdc_pkg::DATA_W-1:0] data_in = 4'h0;
  logic [pdc_pkg::DATA_W-1:0] q_out;
  int errors = 0;
  int checked = 0;
  int cycles = 0;

  pdc_counter pdc_counter_inst (.clk(clk), .nrst(nrst), .count_clk1(count_clk1),
    .count_clk2(count_clk2), .load_n(load_n), .clear_n(clear_n), .data_in(data_in),
    .q_out(q_out));
  pdc_board pdc_board_inst (.ripple(ripple), .clk2_src(clk2_src), .q0(q_out[0]),
    .count_clk2(count_clk2));

  initial begin
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      close_out();
    end
  end

  task automatic settle();
    repeat (8) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string name, input logic [3:0] exp);
    checked++;
    if (q_out !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, q_out);
    end
  endtask

  task automatic set_pins(input logic ld, input logic cl, input logic [3:0] d);
    @(posedge clk);
    load_n <= ld;
    clear_n <= cl;
    data_in <= d;
    settle();
  endtask

  // one low-then-high pulse on clock 1 (which=0) or clock 2 (which=1)
  task automatic pulse(input bit which);
    @(posedge clk);
    if (which) clk2_src <= 1'b0;
    else count_clk1 <= 1'b0;
    settle();
    @(posedge clk);
    clk2_src <= 1'b1;
    count_clk1 <= 1'b1;
    settle();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_load();
    set_pins(1'b0, 1'b1, 4'h9);
    chk("load 9", 4'h9);
    pulse(1'b0);
    pulse(1'b1);
    chk("load clocks ignored", 4'h9);
    set_pins(1'b0, 1'b1, 4'h6);
    chk("load follows", 4'h6);
    set_pins(1'b1, 1'b1, 4'h3);
    chk("latch hold", 4'h6);
  endtask

  task automatic t_count();
    @(posedge clk);
    count_clk1 <= 1'b0;
    settle();
    chk("clk1 fall", 4'h7);
    @(posedge clk);
    count_clk1 <= 1'b1;
    settle();
    chk("clk1 rise", 4'h7);
    pulse(1'b1);
    chk("div5 to 4", 4'h9);
    pulse(1'b1);
    chk("div5 wrap", 4'h1);
  endtask

  task automatic t_clear();
    set_pins(1'b0, 1'b0, 4'hf);
    chk("clear over load", 4'h0);
    set_pins(1'b1, 1'b0, 4'hf);
    pulse(1'b0);
    pulse(1'b1);
    chk("clear over clocks", 4'h0);
    set_pins(1'b1, 1'b1, 4'hf);
    chk("after clear", 4'h0);
  endtask

  // divide-by-five preset above four wraps to zero on the next fall
  task automatic t_preset_wrap();
    set_pins(1'b0, 1'b1, 4'he);
    chk("preset seven", 4'he);
    set_pins(1'b1, 1'b1, 4'he);
    pulse(1'b1);
    chk("wrap from seven", 4'h0);
  endtask

  task automatic t_decade();
    set_pins(1'b0, 1'b1, 4'h1);
    @(posedge clk);
    ripple <= 1'b1;
    set_pins(1'b1, 1'b1, 4'h0);
    for (int i = 1; i <= 10; i++) begin
      pulse(1'b0);
      chk("decade", 4'((1 + i) % 10));
    end
  endtask

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    settle();
    chk("reset", pdc_pkg::Q_RESET);
    t_load();
    t_count();
    t_clear();
    t_preset_wrap();
    t_decade();
    close_out();
  end
endmodule
